// ===== src/buffer_manager_regs_pkg.sv
// Purpose: Constants shared by the buffer manager register block
// Assumes: Register addresses are word indices on a plain register port
// Notes: Pacing tick derived from a 20 ns unit and the 40 MHz clock
package buffer_manager_regs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PACE_W = 13;
  localparam int NUM_PORTS = 3;
  localparam int NUM_QUEUES = 4;
  // Register indices
  localparam logic [15:0] EGRESS_PACE_P2_Q0_Q1 = 16'h1C11;
  localparam logic [15:0] EGRESS_PACE_P2_Q2_Q3 = 16'h1C12;
  localparam logic [15:0] DEFAULT_TAG_PORT0 = 16'h1C13;
  localparam logic [15:0] DEFAULT_TAG_PORT1 = 16'h1C14;
  localparam logic [15:0] DEFAULT_TAG_PORT2 = 16'h1C15;
  localparam logic [15:0] RATE_DROP_COUNT_PORT0 = 16'h1C16;
  localparam logic [15:0] RATE_DROP_COUNT_PORT1 = 16'h1C17;
  localparam logic [15:0] RATE_DROP_COUNT_PORT2 = 16'h1C18;
  // Field positions
  localparam int PACE_HI_LSB = 13;
  localparam int PACE_LO_LSB = 0;
  localparam int PRIO_LSB = 12;
  localparam int PRIO_W = 3;
  localparam int VID_LSB = 0;
  localparam int VID_W = 12;
  // Reset values
  localparam logic [12:0] PACE_RESET = 13'h0000;
  localparam logic [2:0] PRIO_RESET = 3'h0;
  localparam logic [11:0] VID_RESET = 12'h000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_MAX = 32'hFFFFFFFF;
  // Pacing time unit
  localparam int PACE_UNIT_NS = 20;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PACE_UNIT_PS = PACE_UNIT_NS * 1000;
  // Whole clocks per unit, rounded down, never below one
  localparam int PACE_UNIT_CYC_RAW = PACE_UNIT_PS / CLK_PERIOD_PS;
  localparam int PACE_UNIT_CYC = (PACE_UNIT_CYC_RAW < 1) ? 1 : PACE_UNIT_CYC_RAW;
endpackage

// ===== src/drop_counter.sv
// Purpose: Saturating clear-on-read drop counter
// Assumes: Discard pulses are on the same clock
// Notes: Discard during a clearing read restarts at one
`timescale 1ns/100ps
`default_nettype none
module drop_counter
  import buffer_manager_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Events
  input wire logic discard_i,
  input wire logic clear_i,
  // Value
  output logic [31:0] count_o
);
  logic [31:0] count;
  logic [31:0] next_count;

  always_comb
  begin
    next_count = count;
    if (clear_i)
    begin
      next_count = discard_i ? 32'h00000001 : COUNT_RESET;
    end
    else if (discard_i && count != COUNT_MAX)
    begin
      next_count = count + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count <= 32'h00000000;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign count_o = count;
endmodule
`default_nettype wire

// ===== src/pace_timer.sv
// Purpose: Per-byte egress pacing timer for one queue
// Assumes: tick_i pulses once every PACE_UNIT_CYC clocks, each tick worth TICK_PS
// Notes: Slot is interval plus one units, rounded up to whole ticks
`timescale 1ns/100ps
`default_nettype none
module pace_timer
  import buffer_manager_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic tick_i,
  input wire logic [PACE_W-1:0] interval_i,
  input wire logic byte_sent_i,
  // Status
  output logic byte_ready_o
);
  // Time kept in picoseconds so a 20 ns unit paces right on a 25 ns clock
  localparam int TICK_PS = PACE_UNIT_CYC * CLK_PERIOD_PS;
  localparam int REM_W = $clog2((2 ** PACE_W) * PACE_UNIT_PS + 1);
  localparam logic [REM_W-1:0] UNIT_PS = REM_W'(PACE_UNIT_PS);
  localparam logic [REM_W-1:0] STEP_PS = REM_W'(TICK_PS);

  logic [REM_W-1:0] remain;
  logic [REM_W-1:0] next_remain;

  always_comb
  begin
    next_remain = remain;
    if (byte_sent_i)
    begin
      next_remain = REM_W'(interval_i) * UNIT_PS + UNIT_PS;
    end
    else if (tick_i && remain != '0)
    begin
      // Last partial step ends the slot; a byte never goes early
      next_remain = (remain > STEP_PS) ? remain - STEP_PS : '0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      remain <= '0;
    end
    else
    begin
      remain <= next_remain;
    end
  end

  // Handshake output; a byte may go when the slot has expired
  assign byte_ready_o = (remain == '0);
endmodule
`default_nettype wire

// ===== src/switch_buffer_port_config_regs.sv
// Purpose: Buffer manager pacing, default tag and drop count registers
// Assumes: Single 40 MHz clock; discard and byte pulses are synchronous
// Assumes: Master never raises both strobes in one cycle
// Notes: Registers sit at word indices; reserved bits read as zero
// Notes: Unmapped indices read zero and ignore writes
// Notes: Pacing slots round up to whole clocks, never short
// Notes: Saturation and restart at one live in the drop counters
`timescale 1ns/100ps
`default_nettype none
module switch_buffer_port_config_regs
  import buffer_manager_regs_pkg::*;
#(
  parameter int NPORTS = NUM_PORTS,
  parameter int NQUEUES = NUM_QUEUES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [buffer_manager_regs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [buffer_manager_regs_pkg::DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [buffer_manager_regs_pkg::DATA_W-1:0] rdata_o,
  // Ingress rate-limit discards, one pulse per packet
  input wire logic [NPORTS-1:0] rate_discard_i,
  // Port 2 egress pacing
  input wire logic [NQUEUES-1:0] byte_sent_i,
  output logic [NQUEUES-1:0] byte_ready_o,
  output logic [NQUEUES*buffer_manager_regs_pkg::PACE_W-1:0] pace_interval_o,
  // Default tags for egress insert or change
  output logic [NPORTS*buffer_manager_regs_pkg::PRIO_W-1:0] default_prio_o,
  output logic [NPORTS*buffer_manager_regs_pkg::VID_W-1:0] default_vid_o
);
  import buffer_manager_regs_pkg::*;

  // Elaboration checks; decode loops assume these counts and contiguous indices
  if (NPORTS != NUM_PORTS || NQUEUES != NUM_QUEUES)
  begin : g_bad_count
    $error("Register map serves exactly three ports and four queues");
  end
  if (ADDR_W < 16 || DATA_W < 32)
  begin : g_bad_width
    $error("Register port narrower than the map");
  end
  if (DEFAULT_TAG_PORT2 != DEFAULT_TAG_PORT0 + 16'(NUM_PORTS - 1))
  begin : g_bad_tag_map
    $error("Default tag indices must be contiguous");
  end
  if (RATE_DROP_COUNT_PORT2 != RATE_DROP_COUNT_PORT0 + 16'(NUM_PORTS - 1))
  begin : g_bad_drop_map
    $error("Drop count indices must be contiguous");
  end
  if (PACE_HI_LSB < PACE_LO_LSB + PACE_W || PRIO_LSB < VID_LSB + VID_W)
  begin : g_bad_fields
    $error("Packed fields overlap");
  end
  if (PACE_HI_LSB + PACE_W > DATA_W || PRIO_LSB + PRIO_W > DATA_W)
  begin : g_bad_fit
    $error("Packed fields do not fit the data word");
  end
  if (PACE_UNIT_CYC > 256)
  begin : g_bad_div
    $error("Pacing divider cannot count this many clocks");
  end

  // Configuration state
  logic [PACE_W-1:0] pace [NQUEUES];
  logic [PACE_W-1:0] next_pace [NQUEUES];
  logic [PRIO_W-1:0] prio [NPORTS];
  logic [PRIO_W-1:0] next_prio [NPORTS];
  logic [VID_W-1:0] vid [NPORTS];
  logic [VID_W-1:0] next_vid [NPORTS];
  // Read and count state
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [31:0] count [NPORTS];
  logic [NPORTS-1:0] clear;
  logic sel_pace_q01;
  logic sel_pace_q23;
  logic [NPORTS-1:0] sel_tag;
  logic [NPORTS-1:0] sel_drop;
  // Pacing tick
  logic [7:0] tick_div;
  logic [7:0] next_tick_div;
  logic tick;

  // Word index decode, used in several places
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == idx);
  endfunction

  function automatic logic [DATA_W-1:0] pack_pace(input logic [PACE_W-1:0] hi, input logic [PACE_W-1:0] lo);
    pack_pace = '0;
    pack_pace[PACE_HI_LSB +: PACE_W] = hi;
    pack_pace[PACE_LO_LSB +: PACE_W] = lo;
  endfunction

  function automatic logic [DATA_W-1:0] pack_tag(input logic [PRIO_W-1:0] p, input logic [VID_W-1:0] v);
    pack_tag = '0;
    pack_tag[PRIO_LSB +: PRIO_W] = p;
    pack_tag[VID_LSB +: VID_W] = v;
  endfunction

  // Register selects, shared by the write, read and clear paths
  always_comb
  begin
    sel_pace_q01 = hit(addr_i, EGRESS_PACE_P2_Q0_Q1);
    sel_pace_q23 = hit(addr_i, EGRESS_PACE_P2_Q2_Q3);
    for (int p = 0; p < NPORTS; p++)
    begin
      sel_tag[p] = hit(addr_i, DEFAULT_TAG_PORT0 + 16'(p));
      sel_drop[p] = hit(addr_i, RATE_DROP_COUNT_PORT0 + 16'(p));
    end
  end

  // Pacing intervals
  always_comb
  begin
    for (int q = 0; q < NQUEUES; q++)
    begin
      next_pace[q] = pace[q];
    end
    if (write_i && sel_pace_q01)
    begin
      next_pace[0] = wdata_i[PACE_LO_LSB +: PACE_W];
      next_pace[1] = wdata_i[PACE_HI_LSB +: PACE_W];
    end
    if (write_i && sel_pace_q23)
    begin
      next_pace[2] = wdata_i[PACE_LO_LSB +: PACE_W];
      next_pace[3] = wdata_i[PACE_HI_LSB +: PACE_W];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int q = 0; q < NQUEUES; q++)
      begin
        pace[q] <= PACE_RESET;
      end
    end
    else
    begin
      pace <= next_pace;
    end
  end

  // Default tags, one register per port
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      next_prio[p] = prio[p];
      next_vid[p] = vid[p];
      if (write_i && sel_tag[p])
      begin
        next_prio[p] = wdata_i[PRIO_LSB +: PRIO_W];
        next_vid[p] = wdata_i[VID_LSB +: VID_W];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        prio[p] <= PRIO_RESET;
        vid[p] <= VID_RESET;
      end
    end
    else
    begin
      prio <= next_prio;
      vid <= next_vid;
    end
  end

  // Read path; data stands one cycle after the strobe only
  always_comb
  begin
    next_rdata = '0;
    if (read_i)
    begin
      if (sel_pace_q01)
      begin
        next_rdata = pack_pace(pace[1], pace[0]);
      end
      if (sel_pace_q23)
      begin
        next_rdata = pack_pace(pace[3], pace[2]);
      end
      for (int p = 0; p < NPORTS; p++)
      begin
        if (sel_tag[p])
        begin
          next_rdata = pack_tag(prio[p], vid[p]);
        end
        if (sel_drop[p])
        begin
          next_rdata = count[p];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;

  // Drop counters; clear rides the same edge that captures the value
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      // A discard in the clearing cycle survives as a count of one
      clear[p] = read_i && sel_drop[p];
    end
  end

  for (genvar p = 0; p < NPORTS; p++)
  begin : g_count
    drop_counter u_count (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .discard_i(rate_discard_i[p]),
      .clear_i(clear[p]),
      .count_o(count[p])
    );
  end

  // Pacing unit divider; 20 ns is under one 25 ns clock, so one tick per clock
  always_comb
  begin
    next_tick_div = tick_div + 8'h01;
    if (tick_div >= 8'(PACE_UNIT_CYC - 1))
    begin
      next_tick_div = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tick_div <= 8'h00;
    end
    else
    begin
      tick_div <= next_tick_div;
    end
  end

  assign tick = (tick_div >= 8'(PACE_UNIT_CYC - 1));

  for (genvar q = 0; q < NQUEUES; q++)
  begin : g_pace
    pace_timer u_pace (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(tick),
      .interval_i(pace[q]),
      .byte_sent_i(byte_sent_i[q]),
      .byte_ready_o(byte_ready_o[q])
    );
    // Raw field also goes out for the egress scheduler
    assign pace_interval_o[q*PACE_W +: PACE_W] = pace[q];
  end

  for (genvar p = 0; p < NPORTS; p++)
  begin : g_tag
    assign default_prio_o[p*PRIO_W +: PRIO_W] = prio[p];
    assign default_vid_o[p*VID_W +: VID_W] = vid[p];
  end
endmodule
`default_nettype wire

// ===== verif/switch_buffer_port_config_regs_assertions.sv
// Purpose: Port checks for buffer manager registers
// Assumes: Sees only the top module ports
// Notes: Saturation is out of reach here
`timescale 1ns/100ps
`default_nettype none
module switch_buffer_port_config_regs_assertions
  import buffer_manager_regs_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter int NQUEUES = 4
)
(
  // Clock, reset, register port
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // Traffic side
  input wire logic [NPORTS-1:0] rate_discard_i,
  input wire logic [NQUEUES-1:0] byte_sent_i,
  input wire logic [NQUEUES-1:0] byte_ready_o,
  input wire logic [NQUEUES*PACE_W-1:0] pace_interval_o,
  input wire logic [NPORTS*PRIO_W-1:0] default_prio_o,
  input wire logic [NPORTS*VID_W-1:0] default_vid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_read_idle: assert property (!read_i |=> rdata_o == 32'h0)
    else $error("rdata not idle");
  a_pace_low: assert property (write_i && addr_i == EGRESS_PACE_P2_Q0_Q1
    |=> pace_interval_o[25:0] == $past(wdata_i[25:0])) else $error("q0 q1 not written");
  a_pace_high: assert property (write_i && addr_i == EGRESS_PACE_P2_Q2_Q3
    |=> pace_interval_o[51:26] == $past(wdata_i[25:0])) else $error("q2 q3 not written");
  a_tag_port0: assert property (write_i && addr_i == DEFAULT_TAG_PORT0
    |=> {default_prio_o[2:0], default_vid_o[11:0]} == $past(wdata_i[14:0])) else $error("tag 0 wrong");
  a_slot_start: assert property (byte_sent_i[0] |=> !byte_ready_o[0])
    else $error("slot not started");
  a_slot_end: assert property (byte_sent_i[1] && pace_interval_o[25:13] == 13'h0
    ##1 !byte_sent_i[1] |=> byte_ready_o[1]) else $error("slot too long");
  a_drop_clear: assert property (read_i && addr_i == RATE_DROP_COUNT_PORT1 && !rate_discard_i[1]
    ##1 !rate_discard_i[1] ##1 read_i && addr_i == RATE_DROP_COUNT_PORT1 && !rate_discard_i[1]
    |=> rdata_o == 32'h0) else $error("count not cleared");
  a_drop_one: assert property (read_i && addr_i == RATE_DROP_COUNT_PORT2 && rate_discard_i[2]
    ##1 !rate_discard_i[2] ##1 read_i && addr_i == RATE_DROP_COUNT_PORT2 && !rate_discard_i[2]
    |=> rdata_o == 32'h1) else $error("count not one");
endmodule
`default_nettype wire

// ===== verif/switch_buffer_port_config_regs_tb_top.sv
// Purpose: Self-checking bench for buffer manager registers
// Assumes: 20 ns pacing unit on a 25 ns clock, slots round up
// Notes: Saturation needs 2^32 drops, left out
`timescale 1ns/100ps
`default_nettype none
module switch_buffer_port_config_regs_tb_top;
  import buffer_manager_regs_pkg::*;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [15:0] addr_i = 16'h0;
  logic [31:0] wdata_i = 32'h0;
  logic write_i = 1'h0;
  logic read_i = 1'h0;
  logic [31:0] rdata_o;
  logic [2:0] rate_discard_i = 3'h0;
  logic [3:0] byte_sent_i = 4'h0;
  logic [3:0] byte_ready_o;
  logic [51:0] pace_interval_o;
  logic [8:0] default_prio_o;
  logic [35:0] default_vid_o;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 clk_i = ~clk_i;
  switch_buffer_port_config_regs dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .rate_discard_i(rate_discard_i), .byte_sent_i(byte_sent_i), .byte_ready_o(byte_ready_o),
    .pace_interval_o(pace_interval_o), .default_prio_o(default_prio_o), .default_vid_o(default_vid_o));
  task automatic tally_and_finish();
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'h1;
    @(posedge clk_i);
    write_i <= 1'h0;
    #1;
  endtask
  // Discard may ride along with the read
  task automatic rdc(input logic [15:0] a, input logic [2:0] dis, input logic [31:0] e, input string m);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'h1;
    rate_discard_i <= dis;
    @(posedge clk_i);
    read_i <= 1'h0;
    rate_discard_i <= 3'h0;
    #1;
    chk(rdata_o, e, m);
  endtask
  // Bounded wait, a stuck ready still ends
  task automatic slot(input int q, input int n);
    int k;
    k = 0;
    @(posedge clk_i);
    byte_sent_i <= 4'h1 << q;
    @(posedge clk_i);
    byte_sent_i <= 4'h0;
    #1;
    while (byte_ready_o[q] !== 1'h1 && k < 20)
    begin
      k++;
      @(posedge clk_i);
      #1;
    end
    chk(32'(k), 32'(n), "slot length");
  endtask
  task automatic t_reset();
    chk({28'h0, byte_ready_o}, 32'hF, "ready");
    chk({31'h0, |{pace_interval_o, default_prio_o, default_vid_o}}, 32'h0, "outputs");
    for (int i = 0; i < 9; i++)
      rdc(16'h1C11 + 16'(i), 3'h0, 32'h0, "reset read");
    $display("test reset done");
  endtask
  task automatic t_pace();
    wr(EGRESS_PACE_P2_Q0_Q1, 32'hFFFFFFFF);
    rdc(EGRESS_PACE_P2_Q0_Q1, 3'h0, 32'h03FFFFFF, "pace mask");
    wr(EGRESS_PACE_P2_Q0_Q1, 32'h5);
    slot(0, 5);
    slot(1, 1);
    wr(EGRESS_PACE_P2_Q2_Q3, 32'h4003);
    chk(32'(pace_interval_o[51:26]), 32'h4003, "q2 q3");
    slot(2, 4);
    slot(3, 3);
    rdc(EGRESS_PACE_P2_Q2_Q3, 3'h0, 32'h4003, "pace read");
    $display("test pace done");
  endtask
  task automatic t_tag();
    logic [31:0] e;
    for (int p = 0; p < 3; p++)
      wr(DEFAULT_TAG_PORT0 + 16'(p), 32'hFFFF8000 | 32'(32'h1111 * (p + 1)));
    wr(16'h1C19, 32'hFFFF);
    rdc(16'h1C19, 3'h0, 32'h0, "unmapped");
    for (int p = 0; p < 3; p++)
    begin
      e = 32'(32'h1111 * (p + 1));
      rdc(DEFAULT_TAG_PORT0 + 16'(p), 3'h0, e, "tag read");
      chk({29'h0, default_prio_o[p*3+:3]}, 32'(p + 1), "prio");
      chk({20'h0, default_vid_o[p*12+:12]}, e & 32'hFFF, "vid");
    end
    $display("test tag done");
  endtask
  task automatic t_drop();
    for (int p = 0; p < 3; p++)
    begin
      repeat (p + 2)
      begin
        @(posedge clk_i);
        rate_discard_i <= 3'h1 << p;
      end
      @(posedge clk_i);
      rate_discard_i <= 3'h0;
      rdc(RATE_DROP_COUNT_PORT0 + 16'(p), 3'h0, 32'(p + 2), "count");
      rdc(RATE_DROP_COUNT_PORT0 + 16'(p), 3'h0, 32'h0, "cleared");
      rdc(RATE_DROP_COUNT_PORT0 + 16'(p), 3'h1 << p, 32'h0, "hit read");
      rdc(RATE_DROP_COUNT_PORT0 + 16'(p), 3'h0, 32'h1, "restart");
    end
    $display("test drop done");
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    #1;
    t_reset();
    t_pace();
    t_tag();
    t_drop();
    tally_and_finish();
  end
endmodule
bind switch_buffer_port_config_regs switch_buffer_port_config_regs_assertions #(.NPORTS(NPORTS),
  .NQUEUES(NQUEUES)) sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .rate_discard_i(rate_discard_i),
  .byte_sent_i(byte_sent_i), .byte_ready_o(byte_ready_o), .pace_interval_o(pace_interval_o),
  .default_prio_o(default_prio_o), .default_vid_o(default_vid_o));
`default_nettype wire
